// [verilog/esp_pkg.sv]
// constants for the enhanced serial port
package esp_pkg;
    // apb byte offsets
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_BUFFER = 8'h04;
    localparam logic [7:0] OFS_TIMING = 8'h08;
    localparam logic [7:0] OFS_T2_RELOAD = 8'h0c;
    localparam logic [7:0] OFS_T2_CONTROL = 8'h10;
    localparam logic [7:0] OFS_ADDRESS = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    // serial_control fields
    localparam int BIT_RX_DONE = 0;
    localparam int BIT_TX_DONE = 1;
    localparam int BIT_RX_NINTH = 2;
    localparam int BIT_TX_NINTH = 3;
    localparam int BIT_RX_ENABLE = 4;
    localparam int BIT_FILTER = 5;
    localparam int BIT_MODE_LO = 6;
    // timing register fields
    localparam int BIT_T1_CLOCK_SELECT = 8;
    localparam int BIT_DOUBLER = 9;
    // second_timer_control fields
    localparam int BIT_TX_TIMER_SELECT = 4;
    localparam int BIT_RX_TIMER_SELECT = 5;
    // status fields
    localparam int BIT_OVERRUN = 0;
    localparam int BIT_TX_BUSY = 1;
    localparam int BIT_RX_BUSY = 2;
    // reset values
    localparam logic [7:0] RESET_CONTROL = 8'h00;
    localparam logic [9:0] RESET_TIMING = 10'h000;
    localparam logic [15:0] RESET_T2_RELOAD = 16'h0000;
    localparam logic [7:0] RESET_T2_CONTROL = 8'h00;
    localparam logic [15:0] RESET_ADDRESS = 16'h0000;
    // modes
    localparam logic [1:0] MODE_SYNC = 2'h0;
    localparam logic [1:0] MODE_ASYNC8 = 2'h1;
    localparam logic [1:0] MODE_ASYNC9 = 2'h2;
    // timing counts in system clocks or baud ticks
    localparam logic [3:0] SYNC_DIV_LAST = 4'hb;
    localparam logic [3:0] SYNC_CLOCK_RISE = 4'h6;
    localparam logic [3:0] T1_PRESCALE_LAST = 4'hb;
    localparam logic [1:0] M2_DIV64_LAST = 2'h3;
    localparam logic [3:0] TICKS_LAST = 4'hf;
    localparam logic [3:0] TICKS_MID = 4'h7;
    localparam logic [2:0] BITS_LAST = 3'h7;
    localparam logic [7:0] T1_TOP = 8'hff;
    localparam logic [15:0] T2_TOP = 16'hffff;
    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP, TX_SYNC
    } esp_tx_state_type;
    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_NINTH, RX_STOP, RX_SYNC, RX_SYNC_DONE
    } esp_rx_state_type;
endpackage

// [verilog/esp_serial_port.sv]
// enhanced serial port with apb register access
// Operation
// RULE1: buffer reads return receive register; buffer writes load transmit.
// RULE2: tx_done set when byte sent, rx_done set when byte arrives.
// RULE3: completion flags stay set until software clears them.
// RULE4: received byte held in buffer; overrun flagged on unread overwrite.
// RULE5: mode 0 shifts eight bits at system clock over 12, no framing.
// RULE6: mode 0 drives shift clock on out pin, data on in pin.
// RULE7: mode 0 buffer write sends eight bits lsb first, tx_done after.
// RULE8: mode 0 receive starts when rx enable is 1 and rx_done 0.
// RULE9: mode 0 rx_done set one cycle after eighth bit; then halt. Code restarts receive in the cycle rx_done is set and takes one more byte.
// RULE10: mode 0 in pin is open drain, never driven high.
// RULE11: mode 1 frame is start, eight data lsb first, stop.
// RULE12: modes 1 and 2 buffer write starts send; tx_done at stop start.
// RULE13: mode 1 loads if rx_done 0 and, filtering, stop is 1.
// RULE14: each timer rollover gives one baud clock.
// RULE15: transmit and receive choose their timer independently.
// RULE16: selected second timer runs as baud generator at clock over 2.
// RULE17: first timer baud is doubler-scaled over 32 of its overflow.
// RULE18: second timer baud is clock over 32 times reload span.
// RULE19: mode 2 frame adds ninth bit taken from tx_ninth_bit.
// RULE20: mode 2 stores ninth bit in rx_ninth_bit, ignores stop bit.
// RULE21: mode 2 loads if rx_done 0 and filter off or addressed.
// RULE22: mode 2 baud is clock over 64, or 32 with doubler.
// RULE23: address compared with slave address where mask bit is 1.
// RULE24: receiver starts on falling edge, sixteen ticks per bit.
// RULE25: start not low at mid-bit is dropped; back to idle.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module esp_serial_port (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic serial_out_pin,
    input wire logic serial_in_pin,
    output logic serial_in_out,
    output logic serial_in_oe
);
    import esp_pkg::*;

    logic [7:0] serial_control;
    logic [9:0] timing;
    logic [15:0] second_timer_reload;
    logic [7:0] second_timer_control;
    logic [7:0] slave_address;
    logic [7:0] slave_address_mask;
    logic [7:0] serial_buffer;
    logic overrun;
    logic rx_unread;
    logic [1:0] mode;
    logic baud_doubler;
    logic tx_timer_select;
    logic rx_timer_select;
    logic mapped;
    logic wr;
    logic rd;
    logic buffer_write;
    logic buffer_read;
    logic tx_done_set;
    logic rx_load;
    logic [7:0] rx_load_data;
    logic rx_load_ninth;
    logic [3:0] t1_pre;
    logic [7:0] t1_count;
    logic t1_ovf;
    logic t1_half;
    logic t1_baud;
    logic t2_pre;
    logic [15:0] t2_count;
    logic t2_ovf;
    logic [1:0] m2_count;
    logic m2_tick;
    logic tx_tick;
    logic rx_tick;
    logic [3:0] sync_phase;
    logic sync_bit_end;
    esp_tx_state_type tx_state;
    logic [7:0] tx_shift;
    logic tx_ninth;
    logic [3:0] tx_sub;
    logic [2:0] tx_count;
    esp_rx_state_type rx_state;
    logic [7:0] rx_shift;
    logic rx_ninth;
    logic [3:0] rx_sub;
    logic [2:0] rx_count;
    logic rx_s1;
    logic rx_s2;
    logic rx_s3;
    logic rx_level;
    logic rx_prev;
    logic addr_match;
    logic [31:0] next_prdata;

    assign mode = serial_control[BIT_MODE_LO +: 2];
    assign baud_doubler = timing[BIT_DOUBLER];
    assign tx_timer_select = second_timer_control[BIT_TX_TIMER_SELECT];
    assign rx_timer_select = second_timer_control[BIT_RX_TIMER_SELECT];

    // apb slave, zero wait states
    assign pready = 1'b1;
    assign mapped = (paddr == OFS_CONTROL) || (paddr == OFS_BUFFER) ||
        (paddr == OFS_TIMING) || (paddr == OFS_T2_RELOAD) ||
        (paddr == OFS_T2_CONTROL) || (paddr == OFS_ADDRESS) ||
        (paddr == OFS_STATUS);
    assign pslverr = psel && penable && !mapped;
    assign wr = psel && penable && pwrite && mapped;
    assign rd = psel && penable && !pwrite && mapped;
    assign buffer_write = wr && (paddr == OFS_BUFFER); // RULE1
    assign buffer_read = rd && (paddr == OFS_BUFFER); // RULE1

    always_comb begin
        next_prdata = 32'h00000000;
        unique case (paddr)
            OFS_CONTROL: next_prdata[7:0] = serial_control;
            OFS_BUFFER: next_prdata[7:0] = serial_buffer; // RULE1
            OFS_TIMING: next_prdata[9:0] = timing;
            OFS_T2_RELOAD: next_prdata[15:0] = second_timer_reload;
            OFS_T2_CONTROL: next_prdata[7:0] = second_timer_control;
            OFS_ADDRESS: next_prdata[15:0] = {slave_address_mask,
                slave_address};
            OFS_STATUS: begin
                next_prdata[BIT_OVERRUN] = overrun;
                next_prdata[BIT_TX_BUSY] = tx_state != TX_IDLE;
                next_prdata[BIT_RX_BUSY] = rx_state != RX_IDLE;
            end
            default: next_prdata = 32'h00000000;
        endcase
    end

    // read data captured in the setup cycle, valid in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // serial_control: hardware sets win over software writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_control <= RESET_CONTROL;
        end else begin
            if (wr && paddr == OFS_CONTROL) begin
                serial_control <= pwdata[7:0]; // RULE3
            end
            if (tx_done_set) begin
                serial_control[BIT_TX_DONE] <= 1'b1; // RULE2
            end
            if (rx_load) begin
                serial_control[BIT_RX_DONE] <= 1'b1; // RULE2
                serial_control[BIT_RX_NINTH] <= rx_load_ninth;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timing <= RESET_TIMING;
            second_timer_reload <= RESET_T2_RELOAD;
            second_timer_control <= RESET_T2_CONTROL;
            slave_address <= RESET_ADDRESS[7:0];
            slave_address_mask <= RESET_ADDRESS[15:8];
        end else if (wr) begin
            if (paddr == OFS_TIMING) begin
                timing <= pwdata[9:0];
            end
            if (paddr == OFS_T2_RELOAD) begin
                second_timer_reload <= pwdata[15:0];
            end
            if (paddr == OFS_T2_CONTROL) begin
                second_timer_control <= pwdata[7:0];
            end
            if (paddr == OFS_ADDRESS) begin
                slave_address <= pwdata[7:0];
                slave_address_mask <= pwdata[15:8];
            end
        end
    end

    // receive holding register and overrun tracking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_buffer <= 8'h00;
            rx_unread <= 1'b0;
            overrun <= 1'b0;
        end else begin
            if (buffer_read) begin
                rx_unread <= 1'b0;
            end
            if (wr && paddr == OFS_STATUS && pwdata[BIT_OVERRUN]) begin
                overrun <= 1'b0;
            end
            if (rx_load) begin
                serial_buffer <= rx_load_data; // RULE4
                rx_unread <= 1'b1;
                if (rx_unread) begin
                    overrun <= 1'b1; // RULE4
                end
            end
        end
    end

    // first timer: 8-bit auto-reload, clock or clock over 12
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t1_pre <= 4'h0;
            t1_count <= 8'h00;
            t1_half <= 1'b0;
        end else begin
            t1_pre <= (t1_pre == T1_PRESCALE_LAST) ? 4'h0 : t1_pre + 4'h1;
            if (timing[BIT_T1_CLOCK_SELECT] ||
                    t1_pre == T1_PRESCALE_LAST) begin // RULE17
                t1_count <= (t1_count == T1_TOP) ? timing[7:0] :
                    t1_count + 8'h01;
            end
            if (t1_ovf) begin
                t1_half <= !t1_half;
            end
        end
    end
    assign t1_ovf = (t1_count == T1_TOP) &&
        (timing[BIT_T1_CLOCK_SELECT] || t1_pre == T1_PRESCALE_LAST); // RULE14
    assign t1_baud = t1_ovf && (baud_doubler || t1_half); // RULE17

    // second timer: baud generator at clock over 2 while selected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t2_pre <= 1'b0;
            t2_count <= 16'h0000;
        end else if (tx_timer_select || rx_timer_select) begin // RULE16
            t2_pre <= !t2_pre;
            if (t2_pre) begin
                t2_count <= (t2_count == T2_TOP) ? second_timer_reload :
                    t2_count + 16'h0001;
            end
        end else begin
            t2_pre <= 1'b0;
        end
    end
    assign t2_ovf = (tx_timer_select || rx_timer_select) && t2_pre &&
        (t2_count == T2_TOP); // RULE14 RULE18

    // mode 2 fixed divider: tick at clock over 4 or over 2
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            m2_count <= 2'h0;
        end else begin
            m2_count <= m2_count + 2'h1;
        end
    end
    assign m2_tick = baud_doubler ? m2_count[0] :
        (m2_count == M2_DIV64_LAST); // RULE22
    assign tx_tick = (mode == MODE_ASYNC9) ? m2_tick :
        (tx_timer_select ? t2_ovf : t1_baud); // RULE15
    assign rx_tick = (mode == MODE_ASYNC9) ? m2_tick :
        (rx_timer_select ? t2_ovf : t1_baud); // RULE15

    // mode 0 bit timing: 12 clocks, shift clock low then high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_phase <= 4'h0;
        end else if (tx_state == TX_SYNC || rx_state == RX_SYNC) begin
            sync_phase <= sync_bit_end ? 4'h0 : sync_phase + 4'h1; // RULE5
        end else begin
            sync_phase <= 4'h0;
        end
    end
    assign sync_bit_end = sync_phase == SYNC_DIV_LAST;

    // transmitter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state <= TX_IDLE;
            tx_shift <= 8'h00;
            tx_ninth <= 1'b0;
            tx_sub <= 4'h0;
            tx_count <= 3'h0;
            tx_done_set <= 1'b0;
        end else begin
            tx_done_set <= 1'b0;
            if (tx_tick) begin
                tx_sub <= tx_sub + 4'h1;
            end
            unique case (tx_state)
                TX_IDLE: begin
                    tx_count <= 3'h0;
                    tx_sub <= 4'h0;
                    tx_shift <= pwdata[7:0];
                    tx_ninth <= serial_control[BIT_TX_NINTH]; // RULE19
                    if (buffer_write && mode == MODE_SYNC &&
                            rx_state == RX_IDLE) begin
                        tx_state <= TX_SYNC; // RULE7
                    end else if (buffer_write && (mode == MODE_ASYNC8 ||
                            mode == MODE_ASYNC9)) begin
                        tx_state <= TX_START; // RULE12
                    end
                end
                TX_START: begin
                    if (tx_tick && tx_sub == TICKS_LAST) begin
                        tx_state <= TX_DATA;
                    end
                end
                TX_DATA: begin
                    if (tx_tick && tx_sub == TICKS_LAST) begin
                        tx_shift <= {1'b0, tx_shift[7:1]}; // RULE11
                        tx_count <= tx_count + 3'h1;
                        if (tx_count == BITS_LAST) begin
                            tx_state <= (mode == MODE_ASYNC9) ? TX_NINTH :
                                TX_STOP;
                            tx_done_set <= mode != MODE_ASYNC9; // RULE12
                        end
                    end
                end
                TX_NINTH: begin
                    if (tx_tick && tx_sub == TICKS_LAST) begin
                        tx_state <= TX_STOP;
                        tx_done_set <= 1'b1; // RULE12
                    end
                end
                TX_STOP: begin
                    if (tx_tick && tx_sub == TICKS_LAST) begin
                        tx_state <= TX_IDLE;
                    end
                end
                TX_SYNC: begin
                    if (sync_bit_end) begin
                        tx_shift <= {1'b0, tx_shift[7:1]}; // RULE7
                        tx_count <= tx_count + 3'h1;
                        if (tx_count == BITS_LAST) begin
                            tx_state <= TX_IDLE;
                            tx_done_set <= 1'b1; // RULE7
                        end
                    end
                end
            endcase
        end
    end

    // pins: out pin carries data, or the shift clock in mode 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_out_pin <= 1'b1;
            serial_in_oe <= 1'b0;
        end else begin
            if (mode == MODE_SYNC) begin
                serial_out_pin <= !((tx_state == TX_SYNC ||
                    rx_state == RX_SYNC) &&
                    sync_phase < SYNC_CLOCK_RISE); // RULE6
            end else begin
                unique case (tx_state)
                    TX_START: serial_out_pin <= 1'b0;
                    TX_DATA: serial_out_pin <= tx_shift[0];
                    TX_NINTH: serial_out_pin <= tx_ninth;
                    default: serial_out_pin <= 1'b1;
                endcase
            end
            serial_in_oe <= (tx_state == TX_SYNC) && !tx_shift[0]; // RULE10
        end
    end
    assign serial_in_out = 1'b0; // RULE10

    // input pin synchroniser; level moves once stages 2 and 3 agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_s3 <= 1'b1;
            rx_level <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_s1 <= serial_in_pin;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
            if (rx_s2 == rx_s3) begin
                rx_level <= rx_s3;
            end
            rx_prev <= rx_level;
        end
    end

    assign addr_match = ((rx_shift ^ slave_address) &
        slave_address_mask) == 8'h00; // RULE23

    // receiver
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= RX_IDLE;
            rx_shift <= 8'h00;
            rx_ninth <= 1'b0;
            rx_sub <= 4'h0;
            rx_count <= 3'h0;
            rx_load <= 1'b0;
            rx_load_data <= 8'h00;
            rx_load_ninth <= 1'b0;
        end else begin
            rx_load <= 1'b0;
            if (rx_tick) begin
                rx_sub <= rx_sub + 4'h1;
            end
            unique case (rx_state)
                RX_IDLE: begin
                    rx_sub <= 4'h0;
                    rx_count <= 3'h0;
                    if (mode == MODE_SYNC) begin
                        if (serial_control[BIT_RX_ENABLE] &&
                                !serial_control[BIT_RX_DONE] &&
                                tx_state == TX_IDLE && !buffer_write) begin
                            rx_state <= RX_SYNC; // RULE8
                        end
                    end else if ((mode == MODE_ASYNC8 ||
                            mode == MODE_ASYNC9) &&
                            serial_control[BIT_RX_ENABLE] &&
                            rx_prev && !rx_level) begin
                        rx_state <= RX_START; // RULE24
                    end
                end
                RX_START: begin
                    if (rx_tick && rx_sub == TICKS_MID) begin
                        rx_sub <= 4'h0;
                        rx_state <= rx_level ? RX_IDLE : RX_DATA; // RULE25
                    end
                end
                RX_DATA: begin
                    if (rx_tick && rx_sub == TICKS_LAST) begin
                        rx_shift <= {rx_level, rx_shift[7:1]}; // RULE24
                        rx_count <= rx_count + 3'h1;
                        if (rx_count == BITS_LAST) begin
                            rx_state <= (mode == MODE_ASYNC9) ? RX_NINTH :
                                RX_STOP;
                        end
                    end
                end
                RX_NINTH: begin
                    if (rx_tick && rx_sub == TICKS_LAST) begin
                        rx_ninth <= rx_level; // RULE20
                        rx_state <= RX_STOP;
                    end
                end
                RX_STOP: begin
                    if (rx_tick && rx_sub == TICKS_LAST) begin
                        rx_state <= RX_IDLE;
                        rx_load_data <= rx_shift;
                        if (mode == MODE_ASYNC9) begin
                            rx_load_ninth <= rx_ninth; // RULE20
                            rx_load <= !serial_control[BIT_RX_DONE] &&
                                (!serial_control[BIT_FILTER] ||
                                (rx_ninth && addr_match)); // RULE21
                        end else begin
                            rx_load_ninth <= rx_level; // RULE13
                            rx_load <= !serial_control[BIT_RX_DONE] &&
                                (!serial_control[BIT_FILTER] ||
                                rx_level); // RULE13
                        end
                    end
                end
                RX_SYNC: begin
                    if (sync_phase == SYNC_CLOCK_RISE) begin
                        rx_shift <= {rx_level, rx_shift[7:1]};
                    end
                    if (sync_bit_end) begin
                        rx_count <= rx_count + 3'h1;
                        if (rx_count == BITS_LAST) begin
                            rx_state <= RX_SYNC_DONE;
                        end
                    end
                end
                RX_SYNC_DONE: begin
                    rx_state <= RX_IDLE; // RULE9
                    rx_load <= 1'b1;
                    rx_load_data <= rx_shift;
                    rx_load_ninth <= serial_control[BIT_RX_NINTH];
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// [testbench/esp_serial_port_sva.sv]
// checker for the serial port bus answers and pin timing
`timescale 1ns/10ps
`default_nettype none
module esp_serial_port_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serial_out_pin,
    input wire logic serial_in_pin,
    input wire logic serial_in_out,
    input wire logic serial_in_oe
);
    import esp_pkg::*;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    assign acc = psel && penable;
    sequence s_low6;
        !serial_out_pin [*6];
    endsequence
    sequence s_high6;
        serial_out_pin [*6];
    endsequence
    a_zero_wait: assert property (pready)
        else $error("pready low");
    a_err_unmapped: assert property (acc && paddr > OFS_STATUS |-> pslverr)
        else $error("no error on unmapped access");
    a_err_mapped: assert property
        (acc && paddr <= OFS_STATUS && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error on mapped access");
    a_err_reads_zero: assert property
        (acc && !pwrite && pslverr |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_err_access_only: assert property (pslverr |-> acc)
        else $error("error outside access phase");
    a_drain_only: assert property (serial_in_oe |-> !serial_in_out)
        else $error("data pin driven high");
    a_out_low_six: assert property ($fell(serial_out_pin) |-> s_low6)
        else $error("out pin low too short");
    a_out_high_six: assert property ($rose(serial_out_pin) |-> s_high6)
        else $error("out pin high too short");
endmodule
`default_nettype wire

// [testbench/esp_remote.sv]
// remote serial device: frame sender with pulled-up data line
`timescale 1ns/10ps
`default_nettype none
module esp_remote (
    input wire logic clk,
    input wire logic drive_low,
    output logic line
);
    logic lvl = 1'b1;
    // pull-up: line is low only when someone pulls it down
    assign line = (drive_low || !lvl) ? 1'b0 : 1'b1;
    task automatic send(input logic [7:0] d, input logic n9, input int p);
        logic [10:0] f;
        f = {1'b1, n9, d, 1'b0};
        for (int i = 0; i < 11; i++) begin
            lvl <= f[i];
            repeat (p) @(posedge clk);
        end
        repeat (8) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
// testbench for the serial port: registers, mode 0, mode 1 and mode 2 traffic
`timescale 1ns/10ps
`default_nettype none
module tb;
    import esp_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, serial_out_pin, serial_in_pin;
    logic serial_in_out, serial_in_oe;
    int err_total = 0, comparisons = 0;
    always #5 pclk = ~pclk;
    esp_serial_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .serial_out_pin(serial_out_pin), .serial_in_pin(serial_in_pin),
        .serial_in_out(serial_in_out), .serial_in_oe(serial_in_oe));
    esp_remote REM (.clk(pclk), .drive_low(serial_in_oe && !serial_in_out),
        .line(serial_in_pin));
    task automatic print_verdict;
        if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e,
        input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
        input string n);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(n, e, q);
    endtask
    task automatic t_regs;
        rd(OFS_CONTROL, 32'h0, "control");
        wr(OFS_TIMING, 32'h3ab);
        rd(OFS_TIMING, 32'h3ab, "timing");
        rd(8'h1c, 32'h0, "unmapped");
        wr(OFS_TIMING, 32'h0);
    endtask
    task automatic t_mode0_tx;
        logic [7:0] got;
        wr(OFS_BUFFER, 32'h96);
        for (int i = 0; i < 8; i++) begin
            @(posedge serial_out_pin);
            @(negedge pclk);
            got[i] = !serial_in_oe;
        end
        chk("sync data", 32'h96, {24'h0, got});
        repeat (20) @(posedge pclk);
        rd(OFS_CONTROL, 32'h02, "sync tx done");
    endtask
    task automatic t_mode2_tx;
        logic [10:0] f;
        wr(OFS_CONTROL, 32'h88);
        wr(OFS_BUFFER, 32'ha5);
        @(negedge serial_out_pin);
        repeat (32) @(posedge pclk);
        for (int i = 0; i < 11; i++) begin
            f[i] = serial_out_pin;
            repeat (64) @(posedge pclk);
        end
        chk("async frame", {21'h0, 11'h74a}, {21'h0, f});
        rd(OFS_CONTROL, 32'h8a, "async tx done");
    endtask
    task automatic t_mode2_rx;
        wr(OFS_CONTROL, 32'h90);
        REM.send(8'h3c, 1'b1, 64);
        rd(OFS_CONTROL, 32'h95, "rx done");
        rd(OFS_BUFFER, 32'h3c, "rx data");
        REM.send(8'h55, 1'b0, 64);
        rd(OFS_BUFFER, 32'h3c, "held data");
        rd(OFS_CONTROL, 32'h95, "held flags");
    endtask
    task automatic t_filter;
        wr(OFS_CONTROL, 32'hb0);
        wr(OFS_ADDRESS, 32'h0f05);
        REM.send(8'h36, 1'b1, 64);
        rd(OFS_CONTROL, 32'hb0, "address miss");
        REM.send(8'h35, 1'b1, 64);
        rd(OFS_CONTROL, 32'hb5, "address hit");
        rd(OFS_BUFFER, 32'h35, "address byte");
    endtask
    task automatic t_mode1;
        wr(OFS_TIMING, 32'h3ff);
        wr(OFS_CONTROL, 32'h50);
        // let the first timer reach its top before the frame starts
        repeat (300) @(posedge pclk);
        REM.send(8'hc3, 1'b1, 16);
        rd(OFS_CONTROL, 32'h55, "mode1 flags");
        rd(OFS_BUFFER, 32'hc3, "mode1 data");
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_mode0_tx();
        t_mode2_tx();
        t_mode2_rx();
        t_filter();
        t_mode1();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        print_verdict();
    end
endmodule
bind esp_serial_port esp_serial_port_sva SVA (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_out_pin(serial_out_pin),
    .serial_in_pin(serial_in_pin), .serial_in_out(serial_in_out),
    .serial_in_oe(serial_in_oe));
`default_nettype wire
